/* File: verification/move_checker_asserts.sv */
// Port checker for the data-move datapath
`timescale 1ns/1ps
module move_checker
   import move_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [13:0] insn,
   input move_pkg::phase_e phase,
   input move_pkg::index_t file_addr,
   input wire logic file_rd,
   input wire logic [7:0] file_rdata,
   input wire logic file_we,
   input move_pkg::byte_t file_wdata,
   input move_pkg::byte_t acc,
   input wire logic zero_flag,
   input wire logic zero_we
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [13:0] li_r;
   logic [7:0] rd_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         li_r <= 14'h0000;
         rd_r <= 8'h00;
      end else begin
         if (phase == PH_DECODE) li_r <= insn;
         if (phase == PH_READ) rd_r <= file_rdata;
      end
   end
   wire wb = phase == PH_WRITEBACK;
   wire cp = wb && li_r[13:8] == 6'h08;
   property p_lit; wb && li_r[13:10] == 4'hC |=> acc == li_r[7:0]; endproperty
   a_lit: assert property (p_lit) else $error("load");
   property p_rd; phase == PH_READ && li_r[13:8] == 6'h08 |-> file_rd && file_addr == li_r[6:0];
   endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_cw; cp && !li_r[7] |-> !file_we ##1 acc == rd_r; endproperty
   a_cw: assert property (p_cw) else $error("to acc");
   property p_cf; cp && li_r[7] |-> file_we && file_wdata == rd_r; endproperty
   a_cf: assert property (p_cf) else $error("to reg");
   property p_z; cp |-> zero_we && zero_flag == (rd_r == 8'h00); endproperty
   a_z: assert property (p_z) else $error("zero");
   property p_ph; phase == PH_DECODE |=> phase == PH_READ ##1 phase == PH_PROCESS ##1 wb;
   endproperty
   a_ph: assert property (p_ph) else $error("phase");
   property p_st; wb && li_r[13:7] == 7'h01 |-> file_we && file_wdata == acc && !zero_we;
   endproperty
   a_st: assert property (p_st) else $error("store");
   property p_zk; !(phase == PH_PROCESS && li_r[13:8] == 6'h08) |=> $stable(zero_flag);
   endproperty
   a_zk: assert property (p_zk) else $error("flag kept");
endmodule
bind move_instruction_datapath move_checker i_chk (.clk, .arst_n, .insn, .phase, .file_addr,
   .file_rd, .file_rdata, .file_we, .file_wdata, .acc, .zero_flag, .zero_we);

/* File: verification/tb_top.sv */
// Self-checking bench for the data-move datapath
`timescale 1ns/1ps
module tb_top;
   import move_pkg::*;
   logic clk = 0, arst_n = 0, file_rd, file_we, zero_flag, zero_we;
   logic [13:0] insn = 0;
   logic [7:0] file_rdata = 0;
   phase_e phase;
   index_t file_addr;
   byte_t file_wdata, acc;
   int n_errors = 0, n_compared = 0, cyc = 0;
   always #25 clk = ~clk;
   move_instruction_datapath i_dut (.clk, .arst_n, .insn, .phase, .file_addr, .file_rd,
      .file_rdata, .file_we, .file_wdata, .acc, .zero_flag, .zero_we);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Returns in the writeback phase of the applied instruction
   task op(input logic [13:0] i, input logic [7:0] d);
      insn = i;
      file_rdata = d;
      @(posedge clk);
      #5;
      chk(file_rd, i[13:8] == 6'h08);
      repeat (2) @(posedge clk);
      #5;
   endtask
   task nx;
      @(posedge clk);
      #5;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 100) begin
         n_errors++;
         finish_test;
      end
   end
   task t_load;
      op(14'h33FF, 8'h00); // Don't-care opcode bits set
      chk(zero_we, 0);
      nx;
      chk(acc, 8'hFF);
   endtask
   task t_copy_acc;
      op(14'h087F, 8'h00);
      chk(phase, 8'h08);
      chk(zero_flag, 1);
      chk(file_we, 0);
      nx;
      chk(acc, 8'h00);
   endtask
   task t_copy_file;
      op(14'h0885, 8'hA5);
      chk(file_addr, 8'h05);
      chk(file_we, 1);
      chk(file_wdata, 8'hA5);
      chk(zero_flag, 0);
      nx;
      chk(acc, 8'h00);
   endtask
   task t_store;
      op(14'h305A, 8'h00);
      nx;
      chk(acc, 8'h5A);
      op(14'h00FF, 8'h33);
      chk(file_addr, 8'h7F);
      chk(file_we, 1);
      chk(file_wdata, 8'h5A);
      chk(zero_we, 0);
      chk(zero_flag, 0);
      nx;
   endtask
   task t_none;
      op(14'h0000, 8'h00);
      chk(file_we, 0);
      chk(zero_we, 0);
      nx;
      chk(acc, 8'h5A);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #5 arst_n = 1;
      t_load;
      t_copy_acc;
      t_copy_file;
      t_store;
      t_none;
      finish_test;
   end
endmodule

/* File: verilog/move_consts.svh */
// Constants for the data-move instruction datapath
`ifndef MOVE_CONSTS_SVH
`define MOVE_CONSTS_SVH
// ==========================================
// Instruction fields
`define INSN_W 14
`define DATA_W 8
`define ADDR_W 7
`define LIT_TOP_MATCH 4'hC
`define COPY_TOP_MATCH 6'h08
`define STORE_TOP_MATCH 7'h01
`define TARGET_BIT 7
`define OPCODE_MSB 13
`define LIT_LSB 10
`define COPY_LSB 8
`define STORE_LSB 7
// ==========================================
// Timing
`define PHASE_COUNT 4
// ==========================================
// Reset values
`define ACC_RESET 8'h00
`define ZERO_FLAG_RESET 1'b0
`define INSN_RESET 14'h0000
`define DATA_RESET 8'h00
`define ZERO_BYTE 8'h00
`endif

/* File: verilog/move_instruction_datapath.sv */
// Decode and execute of the three data-move instructions
`timescale 1ns/1ps
`include "move_consts.svh"

// Function
// - The load-immediate op puts its 8-bit literal into the accumulator, ignoring bits 9:8.
// - The copy-register op reads the file register named by its 7-bit index.
// - With target-select 0 the copy-register value goes to the accumulator only.
// - With target-select 1 the copy-register value is written back to the same register.
// - The copy-register op updates the zero flag from the moved value for either target.
// - Each op takes one cycle: decode, read, process, then write in the writeback phase.
module move_instruction_datapath
   import move_pkg::*;
#(
   parameter int INSN_W = `INSN_W,
   parameter int DATA_W = `DATA_W,
   parameter int ADDR_W = `ADDR_W
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`INSN_W-1:0] insn,
   output move_pkg::phase_e phase,
   output move_pkg::index_t file_addr,
   output logic file_rd,
   input wire logic [`DATA_W-1:0] file_rdata,
   output logic file_we,
   output move_pkg::byte_t file_wdata,
   output move_pkg::byte_t acc,
   output logic zero_flag,
   output logic zero_we
);
   import move_pkg::*;

   // ==========================================
   // Elaboration checks
   // Ports are typed from the package and the width macros, so the parameters may only restate those widths
   if (INSN_W != `INSN_W) begin : g_insn_w_check
      $error("INSN_W must equal the instruction word width");
   end
   if (DATA_W != $bits(byte_t)) begin : g_data_w_check
      $error("DATA_W must equal the byte type width");
   end
   if (ADDR_W != $bits(index_t)) begin : g_addr_w_check
      $error("ADDR_W must equal the register index width");
   end
   if (`OPCODE_MSB != INSN_W - 1) begin : g_opcode_check
      $error("The opcode field must end at the top of the word");
   end
   if (`TARGET_BIT != ADDR_W) begin : g_target_check
      $error("The target-select bit must sit just above the index");
   end
   if (`STORE_LSB != ADDR_W) begin : g_store_check
      $error("The store opcode must start just above the index");
   end
   if (`COPY_LSB != `TARGET_BIT + 1) begin : g_copy_check
      $error("The copy opcode must start just above the target-select bit");
   end
   if (DATA_W != `COPY_LSB) begin : g_literal_check
      $error("The literal must fill the bits below the opcode");
   end
   if (`LIT_LSB != `COPY_LSB + 2) begin : g_lit_check
      $error("The load opcode leaves exactly two don't-care bits");
   end
   if (`PHASE_COUNT != $bits(phase_e)) begin : g_phase_check
      $error("The phase type must hold one bit per phase");
   end

   // ==========================================
   // State and next values
   logic [INSN_W-1:0] insn_r;
   logic [INSN_W-1:0] insn_nxt;
   byte_t data_r;
   byte_t data_nxt;
   byte_t read_val;
   byte_t wdata_r;
   byte_t wdata_nxt;
   logic we_r;
   logic we_nxt;
   logic zwe_r;
   logic zwe_nxt;
   logic zero_r;
   logic zero_nxt;
   byte_t acc_r;
   byte_t acc_nxt;

   // ==========================================
   // Phase sequencing
   phase_counter u_phase (
      .clk(clk),
      .arst_n(arst_n),
      .phase(phase)
   );

   wire in_decode = (phase == PH_DECODE);
   wire in_read = (phase == PH_READ);
   wire in_process = (phase == PH_PROCESS);
   wire in_wb = (phase == PH_WRITEBACK);

   // ==========================================
   // Instruction latch
   // Taken at the end of decode so the fetch side may move on during the cycle
   assign insn_nxt = in_decode ? insn : insn_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         insn_r <= `INSN_RESET;
      end else begin
         insn_r <= insn_nxt;
      end
   end

   // ==========================================
   // Field extraction
   wire [`OPCODE_MSB-`LIT_LSB:0] lit_top = insn_r[`OPCODE_MSB:`LIT_LSB];
   wire [`OPCODE_MSB-`COPY_LSB:0] copy_top = insn_r[`OPCODE_MSB:`COPY_LSB];
   wire [`OPCODE_MSB-`STORE_LSB:0] store_top = insn_r[`OPCODE_MSB:`STORE_LSB];
   wire target_file = insn_r[`TARGET_BIT];
   wire [DATA_W-1:0] literal = insn_r[DATA_W-1:0];
   wire [ADDR_W-1:0] reg_index = insn_r[ADDR_W-1:0];

   // ==========================================
   // Opcode decode
   // The two don't-care bits of the load opcode sit below lit_top and never reach the match
   wire is_lit = (lit_top == `LIT_TOP_MATCH);
   wire is_copy = (copy_top == `COPY_TOP_MATCH);
   wire is_store = (store_top == `STORE_TOP_MATCH);
   wire copy_to_acc = is_copy && !target_file;
   wire copy_to_file = is_copy && target_file;
   wire loads_acc = is_lit || copy_to_acc;
   wire writes_file = copy_to_file || is_store;
   // Load and store leave the flag alone; any other code drives no strobe at all
   wire sets_zero = is_copy;

   assign file_addr = reg_index;
   assign file_rd = in_read && is_copy;

   // ==========================================
   // Read phase: pick the operand of this op
   assign read_val = is_lit ? literal : (is_store ? acc_r : file_rdata);
   assign data_nxt = in_read ? read_val : data_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_r <= `DATA_RESET;
      end else begin
         data_r <= data_nxt;
      end
   end

   // ==========================================
   // Process phase
   // Strobes, data and flag are formed here so they stand from flops through writeback
   assign we_nxt = in_process && writes_file;
   assign zwe_nxt = in_process && sets_zero;
   assign wdata_nxt = in_process ? data_r : wdata_r;
   assign zero_nxt = (in_process && sets_zero) ? (data_r == `ZERO_BYTE) : zero_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         we_r <= 1'b0;
      end else begin
         we_r <= we_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zwe_r <= 1'b0;
      end else begin
         zwe_r <= zwe_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wdata_r <= `DATA_RESET;
      end else begin
         wdata_r <= wdata_nxt;
      end
   end

   // Kept here for observation; the status register owns the real bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zero_r <= `ZERO_FLAG_RESET;
      end else begin
         zero_r <= zero_nxt;
      end
   end

   // ==========================================
   // Writeback: the accumulator commits on the edge that ends the cycle
   assign acc_nxt = (in_wb && loads_acc) ? wdata_r : acc_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= `ACC_RESET;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign file_we = we_r;
   assign file_wdata = wdata_r;
   assign acc = acc_r;
   assign zero_flag = zero_r;
   assign zero_we = zwe_r;
endmodule

/* File: verilog/move_pkg.sv */
// Types for the data-move instruction datapath
package move_pkg;
   typedef enum logic [3:0] {
      PH_DECODE = 4'b0001,
      PH_READ = 4'b0010,
      PH_PROCESS = 4'b0100,
      PH_WRITEBACK = 4'b1000
   } phase_e;
   typedef logic [7:0] byte_t;
   typedef logic [6:0] index_t;
endpackage

/* File: verilog/phase_counter.sv */
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module phase_counter
   import move_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   output move_pkg::phase_e phase
);
   phase_e phase_r;
   phase_e phase_nxt;

   // ==========================================
   // One instruction cycle is four clock phases
   always_comb begin
      case (phase_r)
         PH_DECODE: phase_nxt = PH_READ;
         PH_READ: phase_nxt = PH_PROCESS;
         PH_PROCESS: phase_nxt = PH_WRITEBACK;
         PH_WRITEBACK: phase_nxt = PH_DECODE;
         default: phase_nxt = PH_DECODE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r <= PH_DECODE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase = phase_r;
endmodule
